// ===== syn_pkg.sv
// package: word layouts, tags and divider constants for the synthesizer serial load and phase logic
// assumes: one 200 MHz clock pclk, asynchronous active-low presetn
package syn_pkg;
  localparam int REF_WORD_LEN  = 16;
  localparam int DIV_WORD_LEN  = 19;
  localparam int REF_DIV_W     = 14;
  localparam int MAIN_W        = 11;
  localparam int SWAL_W        = 7;
  localparam int SHIFT_W       = 19;
  localparam int TAG_POS       = 0;
  localparam int REF_LSB       = 1;
  localparam int RATIO_POS     = 15;
  localparam int SWAL_LSB      = 1;
  localparam int MAIN_LSB      = 8;
  localparam logic TAG_REF     = 1'b1;
  localparam logic TAG_DIV     = 1'b0;
  localparam logic [7:0] PRE_BASE_LO = 8'h40;
  localparam logic [7:0] PRE_BASE_HI = 8'h80;
  localparam logic [13:0] REF_RST  = 14'h0000;
  localparam logic [10:0] MAIN_RST = 11'h000;
  localparam logic [6:0]  SWAL_RST = 7'h00;
  localparam logic        RATIO_RST = 1'b0;
  localparam int HOST_DIV      = 4;
  localparam logic [7:0] ADDR_REF  = 8'h00;
  localparam logic [7:0] ADDR_DIV  = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
endpackage

// ===== syn_if.sv
// interface: three-wire serial port, power save, polarity select between controller and device
// assumes: both ends clocked on pclk; the bench resolves the wires
interface syn_if;
  logic serial_bit_timing_in;   // shift clock
  logic serial_data;            // data line
  logic load_strobe;            // load strobe
  logic power_save_n;           // low places device in power saving
  logic phase_polarity_select;  // pump and phase polarity
  modport device (
    input serial_bit_timing_in,
    input serial_data,
    input load_strobe,
    input power_save_n,
    input phase_polarity_select
  );
  modport host (
    output serial_bit_timing_in,
    output serial_data,
    output load_strobe,
    output power_save_n,
    output phase_polarity_select
  );
endinterface

// ===== syn_sync.sv
// three-flop input synchroniser; output changes once stages two and three agree
// assumes: asynchronous input, pclk domain
module syn_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic pclk,     // clock
  input  wire logic presetn,  // async reset, low
  input  wire logic d,        // raw input
  output logic      q         // filtered level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      q <= RST_VAL;
    else if (s2 == s3)
      q <= s3;
endmodule

// ===== syn_device.sv
// device end: serial shift register, latches, reference and pulse-swallow dividers, phase logic
// assumes: ref_clk_in and vco_in are sampled as pins; pump pins resolved from enables by bench
module syn_device (
  syn_if.device              port_if,        // serial programming port
  input  wire logic          pclk,           // system clock
  input  wire logic          presetn,        // async reset, low
  input  wire logic          ref_clk_in,     // reference oscillator level
  input  wire logic          vco_in,         // vco level
  output logic               pump_out_main,  // main pump drive value
  output logic               pump_main_oe_n, // main pump enable, low drives
  output logic               pump_out_gated, // gated pump drive value
  output logic               pump_gated_oe_n,// gated pump enable, low drives
  output logic               phase_ref,      // reference phase output
  output logic               phase_div,      // divider phase output
  output logic               monitor_out,    // counter monitor
  output logic               active          // high when not power saving
);
  logic sck;
  logic sdat;
  logic lat;
  logic psn;
  logic pol;
  logic rclk;
  logic vclk;
  syn_sync #(.RST_VAL(1'b0)) u_sck (.pclk(pclk), .presetn(presetn),
    .d(port_if.serial_bit_timing_in), .q(sck));
  syn_sync #(.RST_VAL(1'b0)) u_dat (.pclk(pclk), .presetn(presetn),
    .d(port_if.serial_data), .q(sdat));
  syn_sync #(.RST_VAL(1'b0)) u_lat (.pclk(pclk), .presetn(presetn),
    .d(port_if.load_strobe), .q(lat));
  syn_sync #(.RST_VAL(1'b1)) u_psn (.pclk(pclk), .presetn(presetn),
    .d(port_if.power_save_n), .q(psn));
  syn_sync #(.RST_VAL(1'b1)) u_pol (.pclk(pclk), .presetn(presetn),
    .d(port_if.phase_polarity_select), .q(pol));
  syn_sync #(.RST_VAL(1'b0)) u_ref (.pclk(pclk), .presetn(presetn),
    .d(ref_clk_in), .q(rclk));
  syn_sync #(.RST_VAL(1'b0)) u_vco (.pclk(pclk), .presetn(presetn),
    .d(vco_in), .q(vclk));

  logic                             sck_d;
  logic                             lat_d;
  logic                             rclk_d;
  logic                             vclk_d;
  logic [syn_pkg::SHIFT_W-1:0]      shreg;
  logic [4:0]                       nbits;
  logic [syn_pkg::REF_DIV_W-1:0]    ref_div;
  logic                             ratio_sel;
  logic [syn_pkg::MAIN_W-1:0]       main_cnt;
  logic [syn_pkg::SWAL_W-1:0]       swal_cnt;
  wire                              sck_rise = sck & ~sck_d;
  wire                              lat_rise = lat & ~lat_d;
  wire                              ref_tick = rclk & ~rclk_d;
  wire                              vco_tick = vclk & ~vclk_d;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sck_d  <= 1'b0;
      lat_d  <= 1'b0;
      rclk_d <= 1'b0;
      vclk_d <= 1'b0;
    end
    else
    begin
      sck_d  <= sck;
      lat_d  <= lat;
      rclk_d <= rclk;
      vclk_d <= vclk;
    end

  // shift register: no loading in power save
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      shreg <= '0;
      nbits <= 5'h00;
    end
    else if (psn && sck_rise)
    begin
      shreg <= {shreg[syn_pkg::SHIFT_W-2:0], sdat};
      if (nbits != 5'h1f)
        nbits <= nbits + 5'h01;
    end
    else if (psn && lat_rise)
      nbits <= 5'h00;

  // latches keep their contents through power save
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ref_div   <= syn_pkg::REF_RST;
      ratio_sel <= syn_pkg::RATIO_RST;
      main_cnt  <= syn_pkg::MAIN_RST;
      swal_cnt  <= syn_pkg::SWAL_RST;
    end
    else if (psn && lat_rise)
    begin
      if (shreg[syn_pkg::TAG_POS] == syn_pkg::TAG_REF
          && nbits >= 5'(syn_pkg::REF_WORD_LEN))
      begin
        ref_div   <= shreg[syn_pkg::REF_LSB +: syn_pkg::REF_DIV_W];
        ratio_sel <= shreg[syn_pkg::RATIO_POS];
      end
      else if (shreg[syn_pkg::TAG_POS] == syn_pkg::TAG_DIV
               && nbits >= 5'(syn_pkg::DIV_WORD_LEN))
      begin
        main_cnt <= shreg[syn_pkg::MAIN_LSB +: syn_pkg::MAIN_W];
        swal_cnt <= shreg[syn_pkg::SWAL_LSB +: syn_pkg::SWAL_W];
      end
    end

  // reference divider: one pulse every ref_div reference edges
  logic [syn_pkg::REF_DIV_W-1:0] ref_cnt;
  logic                          fr_pulse;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ref_cnt  <= '0;
      fr_pulse <= 1'b0;
    end
    else if (!psn)
    begin
      ref_cnt  <= '0;
      fr_pulse <= 1'b0;
    end
    else
    begin
      fr_pulse <= 1'b0;
      if (ref_tick)
      begin
        if (ref_cnt + 14'h0001 >= ref_div)
        begin
          ref_cnt  <= '0;
          fr_pulse <= 1'b1;
        end
        else
          ref_cnt <= ref_cnt + 14'h0001;
      end
    end

  // dual-modulus prescaler and pulse-swallow counters
  logic [7:0]                pre_cnt;
  logic [syn_pkg::MAIN_W-1:0] m_cnt;
  logic [syn_pkg::SWAL_W-1:0] s_cnt;
  logic                      fp_pulse;
  logic [7:0]                base;
  logic [7:0]                modulus;
  assign base    = ratio_sel ? syn_pkg::PRE_BASE_LO : syn_pkg::PRE_BASE_HI;
  assign modulus = (s_cnt != '0) ? base + 8'h01 : base;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pre_cnt  <= 8'h00;
      m_cnt    <= '0;
      s_cnt    <= '0;
      fp_pulse <= 1'b0;
    end
    else if (!psn)
    begin
      pre_cnt  <= 8'h00;
      m_cnt    <= '0;
      s_cnt    <= '0;
      fp_pulse <= 1'b0;
    end
    else
    begin
      fp_pulse <= 1'b0;
      if (vco_tick)
      begin
        if (pre_cnt + 8'h01 >= modulus)
        begin
          pre_cnt <= 8'h00;
          if (m_cnt + 11'h001 >= main_cnt)
          begin
            m_cnt    <= '0;
            s_cnt    <= swal_cnt;
            fp_pulse <= 1'b1;
          end
          else
          begin
            m_cnt <= m_cnt + 11'h001;
            if (s_cnt != '0)
              s_cnt <= s_cnt - 7'h01;
          end
        end
        else
          pre_cnt <= pre_cnt + 8'h01;
      end
    end

  // phase-frequency detector: up on reference lead, down on divider lead
  logic up;
  logic dn;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      up <= 1'b0;
      dn <= 1'b0;
    end
    else if (!psn)
    begin
      up <= 1'b0;
      dn <= 1'b0;
    end
    else if ((up | fr_pulse) && (dn | fp_pulse))
    begin
      up <= 1'b0;
      dn <= 1'b0;
    end
    else
    begin
      up <= up | fr_pulse;
      dn <= dn | fp_pulse;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pump_out_main   <= 1'b0;
      pump_main_oe_n  <= 1'b1;
      pump_out_gated  <= 1'b0;
      pump_gated_oe_n <= 1'b1;
      phase_ref       <= 1'b0;
      phase_div       <= 1'b1;
      monitor_out     <= 1'b0;
      active          <= 1'b1;
    end
    else
    begin
      active      <= psn;
      monitor_out <= psn & (pol ? fr_pulse : fp_pulse);
      if (up == dn)
      begin
        phase_ref <= 1'b0;
        phase_div <= 1'b1;
      end
      else
      begin
        phase_ref <= (up ^ pol);
        phase_div <= (up ^ pol);
      end
      pump_out_main   <= up ~^ pol;
      pump_out_gated  <= up ~^ pol;
      pump_main_oe_n  <= !(psn && (up != dn));
      pump_gated_oe_n <= !(psn && lat && (up != dn));
    end
endmodule

// ===== syn_host.sv
// controller end: APB slave with command registers, shifts words out on the serial port
// assumes: pclk 200 MHz; serial clock made by dividing pclk
module syn_host (
  syn_if.host               port_if,  // serial programming port
  input  wire logic         pclk,     // clock
  input  wire logic         presetn,  // async reset, low
  input  wire logic         psel,     // apb select
  input  wire logic         penable,  // apb enable
  input  wire logic         pwrite,   // apb direction
  input  wire logic [7:0]   paddr,    // apb address
  input  wire logic [31:0]  pwdata,   // apb write data
  output logic [31:0]       prdata,   // apb read data
  output logic              pready,   // apb ready
  output logic              pslverr   // apb error
);
  localparam logic [7:0] ADDR_REF  = syn_pkg::ADDR_REF;
  localparam logic [7:0] ADDR_DIV  = syn_pkg::ADDR_DIV;
  localparam logic [7:0] ADDR_CTRL = syn_pkg::ADDR_CTRL;
  localparam logic [7:0] ADDR_STAT = syn_pkg::ADDR_STAT;

  typedef enum logic [1:0] {SYN_IDLE, SYN_LOW, SYN_HIGH, SYN_LATCH} syn_state_e;
  syn_state_e               state;
  logic [18:0]              word;
  logic [4:0]               left;
  logic [1:0]               div;
  logic                     tick;
  logic                     ctrl_psn;
  logic                     ctrl_pol;
  wire                      wr = psel & penable & pwrite;
  wire                      busy = (state != SYN_IDLE);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      div <= 2'h0;
    else
      div <= div + 2'h1;
  assign tick = (div == 2'(syn_pkg::HOST_DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > ADDR_STAT);
      unique case (paddr)
        ADDR_CTRL: prdata <= {30'h0000_0000, ctrl_pol, ctrl_psn};
        ADDR_STAT: prdata <= {31'h0000_0000, busy};
        default:   prdata <= 32'h0000_0000;
      endcase
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_psn <= 1'b1;
      ctrl_pol <= 1'b1;
    end
    else if (wr && pready && paddr == ADDR_CTRL)
    begin
      ctrl_psn <= pwdata[0];
      ctrl_pol <= pwdata[1];
    end

  // reference and divider writes start a word; the tag (word bit 3 or bit 0) is shifted last
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state <= SYN_IDLE;
      word  <= '0;
      left  <= 5'h00;
    end
    else
      unique case (state)
        SYN_IDLE:
          if (wr && pready && paddr == ADDR_REF)
          begin
            word  <= {pwdata[15:1], syn_pkg::TAG_REF, 3'h0};
            left  <= 5'(syn_pkg::REF_WORD_LEN);
            state <= SYN_LOW;
          end
          else if (wr && pready && paddr == ADDR_DIV)
          begin
            word  <= {pwdata[18:1], syn_pkg::TAG_DIV};
            left  <= 5'(syn_pkg::DIV_WORD_LEN);
            state <= SYN_LOW;
          end
        SYN_LOW:
          if (tick)
            state <= SYN_HIGH;
        SYN_HIGH:
          if (tick)
          begin
            word <= {word[17:0], 1'b0};
            left <= left - 5'h01;
            state <= (left == 5'h01) ? SYN_LATCH : SYN_LOW;
          end
        SYN_LATCH:
          if (tick)
            state <= SYN_IDLE;
      endcase

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      port_if.serial_bit_timing_in  <= 1'b0;
      port_if.serial_data           <= 1'b0;
      port_if.load_strobe           <= 1'b0;
      port_if.power_save_n          <= 1'b1;
      port_if.phase_polarity_select <= 1'b1;
    end
    else
    begin
      port_if.serial_bit_timing_in  <= (state == SYN_HIGH);
      port_if.serial_data           <= word[18];
      port_if.load_strobe           <= (state == SYN_LATCH);
      port_if.power_save_n          <= ctrl_psn;
      port_if.phase_polarity_select <= ctrl_pol;
    end
endmodule

// ===== syn_chk.sv
// checker: serial port timing, pump enables and phase outputs
// assumes: instantiated beside the interface in the bench top, one pclk domain
module syn_chk (
  input wire logic pclk,                  // clock
  input wire logic presetn,               // async reset, low
  input wire logic serial_bit_timing_in,  // shift clock
  input wire logic serial_data,           // data line
  input wire logic load_strobe,           // load strobe
  input wire logic power_save_n,          // power save, low
  input wire logic pump_out_main,         // main pump value
  input wire logic pump_main_oe_n,        // main pump enable
  input wire logic pump_out_gated,        // gated pump value
  input wire logic pump_gated_oe_n,       // gated pump enable
  input wire logic phase_ref,             // reference phase
  input wire logic phase_div,             // divider phase
  input wire logic active                 // not power saving
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_save_floats_pumps: assert property ((!power_save_n) [*8] |-> pump_main_oe_n && pump_gated_oe_n)
    else $error("pump driven in power save");
  a_save_enters: assert property ($fell(power_save_n) |-> ##[1:8] !active)
    else $error("power save not entered");
  a_save_leaves: assert property ($rose(power_save_n) |-> ##[1:8] active)
    else $error("power save not left");
  a_gated_needs_strobe: assert property ((!load_strobe) [*8] |-> pump_gated_oe_n)
    else $error("gated pump drives without strobe");
  a_gated_copies_main: assert property (!pump_gated_oe_n |-> !pump_main_oe_n && pump_out_gated == pump_out_main)
    else $error("gated pump differs from main pump");
  a_equal_phase_out: assert property (active && pump_main_oe_n |-> !phase_ref && phase_div)
    else $error("phase outputs wrong while pump floats");
  a_pump_vs_phase: assert property (!pump_main_oe_n |-> pump_out_main != phase_ref && phase_ref == phase_div)
    else $error("pump and phase outputs disagree");
  a_data_held: assert property (serial_bit_timing_in |-> $stable(serial_data))
    else $error("data moved while shift clock high");
  a_strobe_clock_low: assert property (load_strobe |-> !serial_bit_timing_in)
    else $error("shift clock high during strobe");

  c_gated: cover property (!pump_gated_oe_n);
  c_strobe: cover property ($rose(load_strobe));
  c_save: cover property (!active);
  c_pump_low: cover property (!pump_main_oe_n && !pump_out_main);
endmodule

// ===== test_synth_serial_load_and_phase_logic.sv
// bench: host and device joined by the interface, driven over apb
// assumes: monitor_out pulses once per reference period with polarity select high, once per divider period with it low; host writes polled via status
module test_synth_serial_load_and_phase_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 90000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        ref_clk_in, vco_in, pump_out_main, pump_main_oe_n, pump_out_gated;
  logic        pump_gated_oe_n, phase_ref, phase_div, monitor_out, active;
  logic        osc_on;
  int          cyc, error_cnt, tests_run;

  syn_if u_syn_if ();
  syn_host u_syn_host (.port_if(u_syn_if.host), .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  syn_device u_syn_device (.port_if(u_syn_if.device), .pclk(pclk), .presetn(presetn),
    .ref_clk_in(ref_clk_in), .vco_in(vco_in), .pump_out_main(pump_out_main),
    .pump_main_oe_n(pump_main_oe_n), .pump_out_gated(pump_out_gated),
    .pump_gated_oe_n(pump_gated_oe_n), .phase_ref(phase_ref), .phase_div(phase_div),
    .monitor_out(monitor_out), .active(active));
  syn_chk u_syn_chk (.pclk(pclk), .presetn(presetn),
    .serial_bit_timing_in(u_syn_if.serial_bit_timing_in), .serial_data(u_syn_if.serial_data),
    .load_strobe(u_syn_if.load_strobe), .power_save_n(u_syn_if.power_save_n),
    .pump_out_main(pump_out_main), .pump_main_oe_n(pump_main_oe_n),
    .pump_out_gated(pump_out_gated), .pump_gated_oe_n(pump_gated_oe_n),
    .phase_ref(phase_ref), .phase_div(phase_div), .active(active));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // reference period 10 cycles, vco period 8 cycles; both still until the idle pins are seen
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    ref_clk_in <= osc_on & ((cyc % 10) < 5);
    vco_in <= osc_on & ((cyc % 8) < 4);
    if (cyc == LIMIT)
    begin
      error_cnt++;
      results;
    end
  end

  task results;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wait_idle;
    logic [31:0] r;
    logic        e;
    do apb(1'b0, 8'h0c, 32'h0000_0000, r, e); while (r[0] !== 1'b0);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    wait_idle;
    apb(1'b1, a, d, r, e);
    repeat (2) @(posedge pclk);
    wait_idle;
    repeat (12) @(posedge pclk);
  endtask

  task wait_pulse;
    @(posedge pclk);
    while (monitor_out !== 1'b1) @(posedge pclk);
  endtask

  // skips two pulses so a fresh load has settled, then times one period
  task measure(input int exp, input string msg);
    int n;
    n = 0;
    wait_pulse;
    wait_pulse;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (monitor_out !== 1'b1);
    chk(32'(n), 32'(exp), msg);
  endtask

  task reset_state;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0003, "control reset");
    chk(32'({pump_main_oe_n, pump_gated_oe_n, phase_ref, phase_div, active}), 32'h0000_001b,
        "idle pins");
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    chk(32'(e), 32'h0000_0001, "unmapped address");
  endtask

  task dividers;
    wr(8'h00, {16'h0000, 1'b1, 14'h0014, 1'b0});
    wr(8'h04, {13'h0000, 11'h003, 7'h02, 1'b0});
    measure(200, "reference period");
    wr(8'h08, 32'h0000_0001);
    measure(8 * (int'(syn_pkg::PRE_BASE_LO) * 3 + 2), "divider 64");
    wr(8'h00, {16'h0000, 1'b0, 14'h0014, 1'b0});
    measure(8 * (int'(syn_pkg::PRE_BASE_HI) * 3 + 2), "divider 128");
  endtask

  // reference runs far faster than the divider, so pump must lean one way
  task direction(input logic pol);
    int hi, lo;
    hi = 0;
    lo = 0;
    wr(8'h08, {30'h0000_0000, pol, 1'b1});
    repeat (4000)
    begin
      @(posedge pclk);
      if (pump_main_oe_n === 1'b0)
        if (pump_out_main === 1'b1) hi++; else lo++;
    end
    chk(32'(hi > lo), 32'(pol), "pump direction");
    chk(32'(hi + lo > 0), 32'h0000_0001, "pump drives");
  endtask

  task power_save;
    wr(8'h08, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    chk(32'({active, pump_main_oe_n, pump_gated_oe_n}), 32'h0000_0003, "saving pins");
    wr(8'h04, {13'h0000, 11'h005, 7'h01, 1'b0});
    wr(8'h08, 32'h0000_0001);
    chk(32'(active), 32'h0000_0001, "saving left");
    measure(8 * (int'(syn_pkg::PRE_BASE_HI) * 3 + 2), "retained divider");
    wr(8'h04, {13'h0000, 11'h005, 7'h01, 1'b0});
    measure(8 * (int'(syn_pkg::PRE_BASE_HI) * 5 + 1), "new divider");
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ref_clk_in = 1'b0;
    vco_in = 1'b0;
    osc_on = 1'b0;
    cyc = 0;
    error_cnt = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    reset_state;
    osc_on <= 1'b1;
    dividers;
    direction(1'b1);
    direction(1'b0);
    power_save;
    results;
  end
endmodule
